// [rtl/pcs_cfg.svh]
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH
// ****************************************
// register command codes
// ****************************************
`define PCS_CMD_CLEAR_FAULTS   16'h0003
`define PCS_REG_IIN_FLT_LIMIT  16'h005b
`define PCS_REG_IIN_FLT_RESP   16'h005c
`define PCS_REG_IIN_WARN_LIMIT 16'h005d
`define PCS_REG_STATUS_BYTE    16'h0078
`define PCS_REG_STATUS_WORD    16'h0079
`define PCS_REG_INPUT_STATUS   16'h007c
`define PCS_REG_FOC_RESP       16'hfe00
`define PCS_REG_FOC_TIMING     16'hfe3d
`define PCS_REG_LEVEL_SHIFT    16'hfe3e
`define PCS_REG_BAL_CFG_A      16'hfe43
`define PCS_REG_BAL_CFG_B      16'hfe95
`define PCS_REG_CS_GAIN        16'hfe60
`define PCS_REG_CS_OFFSET      16'hfe61
`define PCS_REG_CS_RESULT      16'hfe62
`define PCS_REG_VAC_RESULT     16'hfe63
`define PCS_CMD_TRIM_STORE     16'hfe64
// ****************************************
// reset values
// ****************************************
`define PCS_RST_LIMIT          16'h07ff
`define PCS_RST_BYTE           8'h00
`define PCS_RST_GAIN           16'h0400
`define PCS_RST_OFFSET         16'h0000
// ****************************************
// field positions
// ****************************************
`define PCS_RESP_LSB           6
`define PCS_FOC_N_LSB          4
`define PCS_DEB_LSB            3
`define PCS_BLANK_LSB          0
`define PCS_SHIFT_LSB          5
`define PCS_SB_WARN_BIT        0
`define PCS_SW_WARN_BIT        13
`define PCS_IS_WARN_BIT        1
`define PCS_IS_FAULT_BIT       2
`define PCS_IS_FOC_BIT         3
`define PCS_GAIN_FRAC          10
// ****************************************
// timing: ns figures and derived cycles (least times round up)
// ****************************************
`define PCS_CLK_MHZ            100
`define PCS_NS2CYC(ns)         (((ns) * `PCS_CLK_MHZ + 999) / 1000)
`define PCS_DEB_NS0            40
`define PCS_DEB_NS1            80
`define PCS_DEB_NS2            120
`define PCS_DEB_NS3            240
`define PCS_BLK_NS0            40
`define PCS_BLK_NS1            80
`define PCS_BLK_NS2            120
`define PCS_BLK_NS3            160
`define PCS_BLK_NS4            200
`define PCS_BLK_NS5            400
`define PCS_BLK_NS6            600
`define PCS_BLK_NS7            800
`endif

// [rtl/pcs_pkg.sv]
package pcs_pkg;
    // response codes shared by rms and fast overcurrent fields
    typedef enum logic [1:0] {
        PCS_RESP_IGNORE   = 2'b00,
        PCS_RESP_SOFT     = 2'b01,
        PCS_RESP_WAIT_ON  = 2'b10,
        PCS_RESP_RSVD     = 2'b11
    } pcs_resp_t;
    // shutdown sequencer
    typedef enum logic [1:0] {
        PCS_SD_RUN      = 2'b00,
        PCS_SD_WAIT_LOW = 2'b01,
        PCS_SD_WAIT_HI  = 2'b10
    } pcs_sd_t;
endpackage

// [rtl/pcs_sense_protect.sv]
`timescale 1ns/1ps
`include "pcs_cfg.svh"
module pcs_sense_protect #(
    parameter int CNT_W   = 16,
    parameter int DEC_W   = 8,
    parameter int BAL_W   = 12
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 srst,
    // register port
    input  wire logic [15:0]          reg_addr,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [15:0]          reg_wdata,
    output logic      [15:0]          reg_rdata,
    output logic                      reg_err,
    // sense converter samples
    input  wire logic                 cs_valid,
    input  wire logic signed [11:0]   cs_data,
    input  wire logic                 vac_valid,
    input  wire logic [10:0]          vac_data,
    input  wire logic                 half_cycle_end,
    // decimated samples to the loop
    output logic signed [11:0]        cs_loop_sample,
    output logic [10:0]               vac_loop_sample,
    output logic                      loop_sample_valid,
    // pwm link
    input  wire logic                 pwm_leading_edge,
    input  wire logic                 fast_current_limit_input,
    input  wire logic                 supply_on_request,
    output logic                      pulse_terminate,
    output logic                      pwm_shutdown,
    output logic                      soft_start_req,
    output logic [2:0]                level_shift_sel,
    // phase balance
    input  wire logic                 phase_balance_input_valid,
    input  wire logic                 phase_balance_input_phase,
    input  wire logic [11:0]          phase_balance_input,
    output logic signed [BAL_W-1:0]   pwm2_trim,
    // trim store to nonvolatile memory
    output logic                      trim_store_req,
    output logic [31:0]               trim_store_data
);
    import pcs_pkg::*;

    localparam int SW = 11 + CNT_W;

    // refused at elaboration, before any clock runs
    if (CNT_W < 8 || DEC_W < 1 || DEC_W > 16 || BAL_W < 4) begin : g_param_check
        $error("pcs_sense_protect: unsupported parameter values");
    end

    // ****************************************
    // registers
    // ****************************************
    logic [15:0] flt_limit;
    logic [7:0]  flt_resp;
    logic [15:0] warn_limit;
    logic [7:0]  foc_resp;
    logic [7:0]  foc_timing;
    logic [7:0]  lvl_shift;
    logic [7:0]  bal_cfg_a;
    logic [7:0]  bal_cfg_b;
    logic [15:0] cs_gain;
    logic [15:0] cs_offset;
    logic        warn_flag;
    logic        fault_flag;
    logic        foc_flag;
    logic [10:0] cs_result;
    logic [10:0] vac_result;
    logic        clear_req;
    logic        warn_set;
    logic        fault_set;
    logic        foc_set;

    assign clear_req = reg_wr && (reg_addr == `PCS_CMD_CLEAR_FAULTS);

    // software writable configuration
    always_ff @(posedge clk) begin
        if (srst) begin
            flt_limit  <= `PCS_RST_LIMIT;
            flt_resp   <= `PCS_RST_BYTE;
            warn_limit <= `PCS_RST_LIMIT;
            foc_resp   <= `PCS_RST_BYTE;
            foc_timing <= `PCS_RST_BYTE;
            lvl_shift  <= `PCS_RST_BYTE;
            bal_cfg_a  <= `PCS_RST_BYTE;
            bal_cfg_b  <= `PCS_RST_BYTE;
            cs_gain    <= `PCS_RST_GAIN;
            cs_offset  <= `PCS_RST_OFFSET;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `PCS_REG_IIN_FLT_LIMIT:  flt_limit  <= reg_wdata;
                `PCS_REG_IIN_FLT_RESP:   flt_resp   <= reg_wdata[7:0];
                `PCS_REG_IIN_WARN_LIMIT: warn_limit <= reg_wdata;
                `PCS_REG_FOC_RESP:       foc_resp   <= reg_wdata[7:0];
                `PCS_REG_FOC_TIMING:     foc_timing <= reg_wdata[7:0];
                `PCS_REG_LEVEL_SHIFT:    lvl_shift  <= reg_wdata[7:0];
                `PCS_REG_BAL_CFG_A:      bal_cfg_a  <= reg_wdata[7:0];
                `PCS_REG_BAL_CFG_B:      bal_cfg_b  <= reg_wdata[7:0];
                `PCS_REG_CS_GAIN:        cs_gain    <= reg_wdata;
                `PCS_REG_CS_OFFSET:      cs_offset  <= reg_wdata;
                default: ;
            endcase
        end
    end

    // sticky flags; a set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (srst) begin
            warn_flag  <= 1'b0;
            fault_flag <= 1'b0;
            foc_flag   <= 1'b0;
        end else begin
            warn_flag  <= warn_set  | (warn_flag  & ~clear_req);
            fault_flag <= fault_set | (fault_flag & ~clear_req);
            foc_flag   <= foc_set   | (foc_flag   & ~clear_req);
        end
    end

    // registered read data, one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 16'h0000;
            reg_err   <= 1'b0;
        end else if (reg_rd) begin
            reg_err <= 1'b0;
            unique case (reg_addr)
                `PCS_REG_IIN_FLT_LIMIT:  reg_rdata <= flt_limit;
                `PCS_REG_IIN_FLT_RESP:   reg_rdata <= {8'h00, flt_resp};
                `PCS_REG_IIN_WARN_LIMIT: reg_rdata <= warn_limit;
                `PCS_REG_STATUS_BYTE:    reg_rdata <= 16'(warn_flag) << `PCS_SB_WARN_BIT;
                `PCS_REG_STATUS_WORD:    reg_rdata <= (16'(warn_flag) << `PCS_SW_WARN_BIT)
                                                    | (16'(warn_flag) << `PCS_SB_WARN_BIT);
                `PCS_REG_INPUT_STATUS:   reg_rdata <= (16'(warn_flag)  << `PCS_IS_WARN_BIT)
                                                    | (16'(fault_flag) << `PCS_IS_FAULT_BIT)
                                                    | (16'(foc_flag)   << `PCS_IS_FOC_BIT);
                `PCS_REG_FOC_RESP:       reg_rdata <= {8'h00, foc_resp};
                `PCS_REG_FOC_TIMING:     reg_rdata <= {8'h00, foc_timing};
                `PCS_REG_LEVEL_SHIFT:    reg_rdata <= {8'h00, lvl_shift};
                `PCS_REG_BAL_CFG_A:      reg_rdata <= {8'h00, bal_cfg_a};
                `PCS_REG_BAL_CFG_B:      reg_rdata <= {8'h00, bal_cfg_b};
                `PCS_REG_CS_GAIN:        reg_rdata <= cs_gain;
                `PCS_REG_CS_OFFSET:      reg_rdata <= cs_offset;
                `PCS_REG_CS_RESULT:      reg_rdata <= {5'h00, cs_result};
                `PCS_REG_VAC_RESULT:     reg_rdata <= {5'h00, vac_result};
                default: begin
                    reg_rdata <= 16'h0000;
                    reg_err   <= 1'b1;
                end
            endcase
        end
    end

    // trim save: snapshot goes to the nonvolatile store
    always_ff @(posedge clk) begin
        if (srst) begin
            trim_store_req  <= 1'b0;
            trim_store_data <= 32'h0000_0000;
        end else begin
            trim_store_req <= reg_wr && (reg_addr == `PCS_CMD_TRIM_STORE);
            if (reg_wr && reg_addr == `PCS_CMD_TRIM_STORE) begin
                trim_store_data <= {cs_gain, cs_offset};
            end
        end
    end

    // level shift selection follows the register live, no restart
    assign level_shift_sel = lvl_shift[`PCS_SHIFT_LSB +: 3];

    // ****************************************
    // current trim and decimation
    // ****************************************
    logic signed [28:0] cs_prod;
    logic signed [11:0] cs_corr;
    logic [10:0]        cs_abs;
    logic signed [DEC_W+11:0] cs_dec_acc;
    logic [DEC_W+10:0]        vac_dec_acc;

    // gain is unsigned fixed point; wraps on overflow, software keeps trim sane
    assign cs_prod = ($signed(cs_data) * $signed({1'b0, cs_gain})) >>> `PCS_GAIN_FRAC;
    assign cs_corr = 12'(cs_prod + 29'($signed(cs_offset)));
    assign cs_abs  = cs_corr[11] ? 11'(-cs_corr) : cs_corr[10:0];

    // per-period sums, scaled down by the period sample budget
    always_ff @(posedge clk) begin
        if (srst) begin
            cs_dec_acc        <= '0;
            vac_dec_acc       <= '0;
            cs_loop_sample    <= 12'sh000;
            vac_loop_sample   <= 11'h000;
            loop_sample_valid <= 1'b0;
        end else begin
            loop_sample_valid <= pwm_leading_edge;
            if (pwm_leading_edge) begin
                cs_loop_sample  <= 12'(cs_dec_acc >>> DEC_W);
                vac_loop_sample <= 11'(vac_dec_acc >> DEC_W);
                cs_dec_acc      <= cs_valid  ? (DEC_W+12)'(cs_corr) : '0;
                vac_dec_acc     <= vac_valid ? (DEC_W+11)'(vac_data) : '0;
            end else begin
                if (cs_valid)  cs_dec_acc  <= cs_dec_acc + (DEC_W+12)'(cs_corr);
                if (vac_valid) vac_dec_acc <= vac_dec_acc + (DEC_W+11)'(vac_data);
            end
        end
    end

    // ****************************************
    // half-line-cycle results and rms check
    // ****************************************
    logic [SW-1:0]    cs_hsum;
    logic [SW-1:0]    vac_hsum;
    logic [CNT_W-1:0] cs_cnt;
    logic [CNT_W-1:0] vac_cnt;
    logic [SW-1:0]    cs_rem;
    logic [SW-1:0]    vac_rem;
    logic [SW-1:0]    cs_den;
    logic [SW-1:0]    vac_den;
    logic [10:0]      cs_quo;
    logic [10:0]      vac_quo;
    logic [3:0]       div_step;
    logic             div_busy;
    logic             div_done;

    // sums over the half cycle; the divider takes a snapshot at its end
    always_ff @(posedge clk) begin
        if (srst || half_cycle_end) begin
            cs_hsum  <= '0;
            vac_hsum <= '0;
            cs_cnt   <= '0;
            vac_cnt  <= '0;
        end else begin
            if (cs_valid && cs_cnt != '1) begin
                cs_hsum <= cs_hsum + SW'(cs_abs);
                cs_cnt  <= cs_cnt + 1'b1;
            end
            if (vac_valid && vac_cnt != '1) begin
                vac_hsum <= vac_hsum + SW'(vac_data);
                vac_cnt  <= vac_cnt + 1'b1;
            end
        end
    end

    // restoring divider, 11 steps; mean rectified value stands in for rms
    always_ff @(posedge clk) begin
        if (srst) begin
            div_busy <= 1'b0;
            div_done <= 1'b0;
            div_step <= 4'h0;
            cs_rem   <= '0;
            vac_rem  <= '0;
            cs_den   <= '0;
            vac_den  <= '0;
            cs_quo   <= 11'h000;
            vac_quo  <= 11'h000;
        end else begin
            div_done <= 1'b0;
            if (half_cycle_end) begin
                div_busy <= 1'b1;
                div_step <= 4'ha;
                cs_rem   <= cs_hsum;
                vac_rem  <= vac_hsum;
                cs_den   <= SW'(cs_cnt)  << 10;
                vac_den  <= SW'(vac_cnt) << 10;
            end else if (div_busy) begin
                cs_quo[div_step]  <= (cs_rem  >= cs_den)  && (cs_den  != '0);
                vac_quo[div_step] <= (vac_rem >= vac_den) && (vac_den != '0);
                if (cs_rem >= cs_den && cs_den != '0)    cs_rem  <= cs_rem - cs_den;
                if (vac_rem >= vac_den && vac_den != '0) vac_rem <= vac_rem - vac_den;
                cs_den   <= cs_den >> 1;
                vac_den  <= vac_den >> 1;
                div_step <= div_step - 1'b1;
                if (div_step == 4'h0) begin
                    div_busy <= 1'b0;
                    div_done <= 1'b1;
                end
            end
        end
    end

    // results update once per half cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            cs_result  <= 11'h000;
            vac_result <= 11'h000;
        end else if (div_done) begin
            cs_result  <= cs_quo;
            vac_result <= vac_quo;
        end
    end

    assign fault_set = div_done && ({5'h00, cs_quo} > flt_limit);
    assign warn_set  = div_done && ({5'h00, cs_quo} > warn_limit);

    // ****************************************
    // fast overcurrent path
    // ****************************************
    logic       fast_current_limit_input_s1;
    logic       fast_current_limit_input_s2;
    logic       son_s1;
    logic       son_s2;
    logic [7:0] blank_cnt;
    logic [7:0] deb_cnt;
    logic [7:0] blank_len;
    logic [7:0] deb_len;
    logic       trip_q;
    logic       cycle_tripped;
    logic [3:0] trip_cycles;
    logic [3:0] n_limit;
    logic       foc_act;
    pcs_sd_t    sd_state;
    pcs_resp_t  foc_mode;
    pcs_resp_t  rms_mode;

    // two-stage synchronisers for the pins
    always_ff @(posedge clk) begin
        if (srst) begin
            fast_current_limit_input_s1 <= 1'b0;
            fast_current_limit_input_s2 <= 1'b0;
            son_s1  <= 1'b0;
            son_s2  <= 1'b0;
        end else begin
            fast_current_limit_input_s1 <= fast_current_limit_input;
            fast_current_limit_input_s2 <= fast_current_limit_input_s1;
            son_s1  <= supply_on_request;
            son_s2  <= son_s1;
        end
    end

    // timing lookup from the field codes
    always_comb begin
        unique case (foc_timing[`PCS_BLANK_LSB +: 3])
            3'd0: blank_len = 8'(`PCS_NS2CYC(`PCS_BLK_NS0));
            3'd1: blank_len = 8'(`PCS_NS2CYC(`PCS_BLK_NS1));
            3'd2: blank_len = 8'(`PCS_NS2CYC(`PCS_BLK_NS2));
            3'd3: blank_len = 8'(`PCS_NS2CYC(`PCS_BLK_NS3));
            3'd4: blank_len = 8'(`PCS_NS2CYC(`PCS_BLK_NS4));
            3'd5: blank_len = 8'(`PCS_NS2CYC(`PCS_BLK_NS5));
            3'd6: blank_len = 8'(`PCS_NS2CYC(`PCS_BLK_NS6));
            3'd7: blank_len = 8'(`PCS_NS2CYC(`PCS_BLK_NS7));
        endcase
        unique case (foc_timing[`PCS_DEB_LSB +: 2])
            2'd0: deb_len = 8'(`PCS_NS2CYC(`PCS_DEB_NS0));
            2'd1: deb_len = 8'(`PCS_NS2CYC(`PCS_DEB_NS1));
            2'd2: deb_len = 8'(`PCS_NS2CYC(`PCS_DEB_NS2));
            2'd3: deb_len = 8'(`PCS_NS2CYC(`PCS_DEB_NS3));
        endcase
    end

    // blanking from the leading edge, then debounce of the comparator
    always_ff @(posedge clk) begin
        if (srst) begin
            blank_cnt <= 8'h00;
            deb_cnt   <= 8'h00;
            trip_q    <= 1'b0;
        end else if (pwm_leading_edge) begin
            blank_cnt <= blank_len;
            deb_cnt   <= 8'h00;
            trip_q    <= 1'b0;
        end else if (blank_cnt != 8'h00) begin
            blank_cnt <= blank_cnt - 1'b1;
            deb_cnt   <= 8'h00;
        end else if (!fast_current_limit_input_s2) begin
            deb_cnt <= 8'h00;  // short glitch restarts the qualify time
        end else if (deb_cnt < deb_len) begin
            deb_cnt <= deb_cnt + 1'b1;
        end else begin
            trip_q <= 1'b1;  // one trip per period
        end
    end

    // terminate the pulse whatever the response setting
    assign pulse_terminate = (blank_cnt == 8'h00) && fast_current_limit_input_s2 && (deb_cnt >= deb_len) && !trip_q;
    assign foc_set         = pulse_terminate;

    assign foc_mode = pcs_resp_t'(foc_resp[`PCS_RESP_LSB +: 2]);
    assign rms_mode = pcs_resp_t'(flt_resp[`PCS_RESP_LSB +: 2]);
    assign n_limit  = 4'h1 << foc_resp[`PCS_FOC_N_LSB +: 2];
    assign foc_act  = pwm_leading_edge && (cycle_tripped || pulse_terminate)
                      && (5'(trip_cycles) + 5'h01 >= 5'(n_limit))
                      && (foc_mode == PCS_RESP_SOFT || foc_mode == PCS_RESP_WAIT_ON);

    // tripped-cycle counter, cleared by any clean cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            cycle_tripped <= 1'b0;
            trip_cycles   <= 4'h0;
        end else if (pwm_leading_edge) begin
            cycle_tripped <= 1'b0;
            if (!(cycle_tripped || pulse_terminate) || foc_act) begin
                trip_cycles <= 4'h0;
            end else if (trip_cycles != 4'hf) begin
                trip_cycles <= trip_cycles + 1'b1;
            end
        end else if (pulse_terminate) begin
            cycle_tripped <= 1'b1;
        end
    end

    // shutdown actions; otherwise switching simply resumes next cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            sd_state       <= PCS_SD_RUN;
            soft_start_req <= 1'b0;
        end else begin
            soft_start_req <= 1'b0;
            unique case (sd_state)
                PCS_SD_RUN: begin
                    if ((foc_act && foc_mode == PCS_RESP_WAIT_ON)
                        || (fault_set && rms_mode == PCS_RESP_WAIT_ON)) begin
                        sd_state <= son_s2 ? PCS_SD_WAIT_LOW : PCS_SD_WAIT_HI;
                    end else if ((foc_act && foc_mode == PCS_RESP_SOFT)
                                 || (fault_set && rms_mode == PCS_RESP_SOFT)) begin
                        soft_start_req <= 1'b1;
                    end
                end
                PCS_SD_WAIT_LOW: if (!son_s2) sd_state <= PCS_SD_WAIT_HI;
                PCS_SD_WAIT_HI: begin
                    if (son_s2) begin
                        sd_state       <= PCS_SD_RUN;
                        soft_start_req <= 1'b1;
                    end
                end
                default: sd_state <= PCS_SD_RUN;
            endcase
        end
    end

    // shutdown also while the supply-on input is low
    assign pwm_shutdown = (sd_state != PCS_SD_RUN) || !son_s2 || soft_start_req;

    // ****************************************
    // phase current balancing
    // ****************************************
    logic signed [BAL_W+1:0] bal_diff;
    logic signed [BAL_W:0]   bal_step;

    // zero-extended signed step keeps the clamp compares signed
    assign bal_step = $signed({1'b0, BAL_W'(bal_cfg_a[3:0])});

    // per-period difference steps an integrator; several cycles to settle
    always_ff @(posedge clk) begin
        if (srst) begin
            bal_diff  <= '0;
            pwm2_trim <= '0;
        end else if (!bal_cfg_b[0]) begin
            bal_diff  <= '0;
            pwm2_trim <= '0;
        end else if (pwm_leading_edge) begin
            bal_diff <= '0;
            if (bal_diff > 0 && pwm2_trim < $signed({1'b0, {(BAL_W-1){1'b1}}}) - bal_step) begin
                pwm2_trim <= BAL_W'(pwm2_trim + bal_step);
            end else if (bal_diff < 0 && pwm2_trim > $signed({1'b1, {(BAL_W-1){1'b0}}}) + bal_step) begin
                pwm2_trim <= BAL_W'(pwm2_trim - bal_step);
            end
        end else if (phase_balance_input_valid) begin
            // phase 1 adds, phase 0 subtracts: trim follows phase 1 minus phase 0
            bal_diff <= phase_balance_input_phase ? bal_diff + (BAL_W+2)'(phase_balance_input)
                                                  : bal_diff - (BAL_W+2)'(phase_balance_input);
        end
    end
endmodule

// [test/pcs_chk_sva.sv]
`timescale 1ns/1ps
module pcs_chk (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pwm link and loop samples
    input wire logic pwm_leading_edge,
    input wire logic fast_current_limit_input,
    input wire logic supply_on_request,
    input wire logic pulse_terminate,
    input wire logic pwm_shutdown,
    input wire logic soft_start_req,
    input wire logic loop_sample_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // a trip ends the pulse once, never twice in a row
    chk_term_single: assert property (pulse_terminate |=> !pulse_terminate)
        else $error("pulse_terminate held");
    // blank plus debounce keeps the first cycles after the edge quiet
    chk_term_blank: assert property (pwm_leading_edge |=> !pulse_terminate [*6])
        else $error("trip inside blanking");
    // sync delay means the pin was high several cycles earlier
    chk_term_debounce: assert property (pulse_terminate |-> $past(fast_current_limit_input, 3)
        && $past(fast_current_limit_input, 4)) else $error("trip without qualified pin");
    chk_term_glitch: assert property (!fast_current_limit_input [*4] |-> !pulse_terminate)
        else $error("trip with pin low");
    chk_sample_valid: assert property (loop_sample_valid == $past(pwm_leading_edge))
        else $error("loop sample not once per period");
    // supply-on passes two sync stages, so three low cycles must disable
    chk_supply_off: assert property (!supply_on_request [*3] |-> pwm_shutdown)
        else $error("running with supply-on low");
    chk_soft_single: assert property (soft_start_req |=> !soft_start_req)
        else $error("soft start not a pulse");
    chk_soft_shut: assert property (soft_start_req |-> pwm_shutdown)
        else $error("soft start while switching");
    cov_trip: cover property (pulse_terminate);
    cov_soft: cover property (soft_start_req);
    cov_resume: cover property ($fell(pwm_shutdown));
endmodule
bind pcs_sense_protect pcs_chk chk_u (.*);

// [test/testbench.sv]
`timescale 1ns/1ps
`include "pcs_cfg.svh"
module testbench;
    logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, reg_err, cs_valid = 0, vac_valid = 0;
    logic half_cycle_end = 0, pwm_leading_edge = 0, fast_current_limit_input = 0, supply_on_request = 1;
    logic phase_balance_input_valid = 0, phase_balance_input_phase = 0, pulse_terminate, pwm_shutdown;
    logic soft_start_req, loop_sample_valid, trim_store_req;
    logic [15:0] reg_addr = 0, reg_wdata = 0, reg_rdata, v;
    logic signed [11:0] cs_data = 0, cs_loop_sample, pwm2_trim;
    logic [10:0] vac_data = 0, vac_loop_sample;
    logic [11:0] phase_balance_input = 12'h00a;
    logic [2:0]  level_shift_sel;
    logic [31:0] trim_store_data;
    int          err_total = 0, check_count = 0, n_term = 0, n_soft = 0;
    pcs_sense_protect dut_u (.*);
    initial forever #5 clk = ~clk;
    // pulses are one cycle wide, so count them at every edge
    always @(posedge clk) begin
        if (pulse_terminate === 1'b1) n_term++;
        if (soft_start_req === 1'b1) n_soft++;
    end
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wr(logic [15:0] a, logic [15:0] d);
        @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk) reg_wr <= 0;
    endtask
    // read data is registered, valid just after the edge that takes reg_rd
    task automatic rd(logic [15:0] a);
        @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk) reg_rd <= 0;
        #1 v = reg_rdata;
    endtask
    // negative current proves the result is a magnitude
    task automatic hc(logic signed [11:0] c);
        repeat (4) begin
            @(posedge clk) {cs_valid, vac_valid, cs_data, vac_data} <= {2'b11, c, 11'd200};
            @(posedge clk) {cs_valid, vac_valid} <= 2'b00;
        end
        @(posedge clk) {half_cycle_end, pwm_leading_edge} <= 2'b11;
        @(posedge clk) {half_cycle_end, pwm_leading_edge} <= 2'b00;
        repeat (16) @(posedge clk);
    endtask
    task automatic per(logic trip);
        @(posedge clk) pwm_leading_edge <= 1;
        @(posedge clk) pwm_leading_edge <= 0;
        repeat (10) @(posedge clk);
        fast_current_limit_input <= trip;
        repeat (15) @(posedge clk);
        fast_current_limit_input <= 0;
        repeat (20) @(posedge clk);
    endtask
    task automatic bal(logic ph);
        @(posedge clk) {phase_balance_input_valid, phase_balance_input_phase} <= {1'b1, ph};
        @(posedge clk) {phase_balance_input_valid, pwm_leading_edge} <= 2'b01;
        @(posedge clk) pwm_leading_edge <= 0;
    endtask
    task automatic end_sim;
        if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        srst <= 0;
        repeat (4) @(posedge clk);
        #1 chk("shutdown", pwm_shutdown, 0);
        rd(`PCS_REG_IIN_FLT_LIMIT);
        chk("flt_limit", v, `PCS_RST_LIMIT);
        rd(16'h1234);
        chk("unmapped", {reg_err, v[14:0]}, 16'h8000);
        wr(`PCS_REG_LEVEL_SHIFT, 16'h00a0);
        #1 chk("shift", level_shift_sel, 3'b101);
        wr(`PCS_REG_IIN_WARN_LIMIT, 16'h0010);
        hc(-12'sd100);
        chk("dec_cs", cs_loop_sample, 16'hfffe);
        chk("dec_vac", vac_loop_sample, 16'h0003);
        rd(`PCS_REG_STATUS_BYTE);
        chk("sb_warn", v[0], 1);
        rd(`PCS_REG_STATUS_WORD);
        chk("sw_warn", v[13], 1);
        rd(`PCS_REG_INPUT_STATUS);
        chk("is_warn", v[2:1], 2'b01);
        chk("warn_act", n_soft, 0);
        rd(`PCS_REG_CS_RESULT);
        chk("cs_res", v, 16'd100);
        rd(`PCS_REG_VAC_RESULT);
        chk("vac_res", v, 16'd200);
        wr(`PCS_REG_IIN_FLT_RESP, 16'h0040);
        wr(`PCS_REG_IIN_FLT_LIMIT, 16'h0032);
        hc(-12'sd100);
        rd(`PCS_REG_INPUT_STATUS);
        chk("is_fault", v[2], 1);
        chk("flt_act", n_soft, 1);
        // n=2 soft start: a clean cycle in between must clear the count
        wr(`PCS_REG_FOC_TIMING, 16'h0000);
        wr(`PCS_REG_FOC_RESP, 16'h0050);
        per(1);
        per(0);
        per(1);
        per(1);
        chk("foc_wait", n_soft, 1);
        per(0);
        chk("foc_soft", n_soft, 2);
        chk("term", n_term, 3);
        rd(`PCS_REG_INPUT_STATUS);
        chk("is_fast", v[3], 1);
        wr(`PCS_REG_FOC_RESP, 16'h0080);
        per(0);
        per(1);
        per(0);
        #1 chk("wait_sd", pwm_shutdown, 1);
        @(posedge clk) supply_on_request <= 0;
        repeat (6) @(posedge clk);
        supply_on_request <= 1;
        repeat (8) @(posedge clk);
        #1 chk("resume", pwm_shutdown, 0);
        chk("resume_ss", n_soft, 3);
        wr(`PCS_REG_BAL_CFG_A, 16'h0003);
        wr(`PCS_REG_BAL_CFG_B, 16'h0001);
        bal(1);
        #1 chk("bal_up", pwm2_trim, 16'h0003);
        bal(0);
        bal(0);
        #1 chk("bal_dn", pwm2_trim, 16'hfffd);
        wr(`PCS_REG_CS_GAIN, 16'h0200);
        wr(`PCS_REG_CS_OFFSET, 16'h0005);
        wr(`PCS_CMD_TRIM_STORE, 16'h0000);
        #1 chk("st_req", trim_store_req, 1);
        chk("st_gain", trim_store_data[31:16], 16'h0200);
        hc(-12'sd100);
        rd(`PCS_REG_CS_RESULT);
        chk("trim_res", v, 16'h002d);
        end_sim;
    end
endmodule
